// file: hdl/psr_pkg.sv
// shared constants and types of the power state rail sequencer
package psr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RAIL_N = 32;

    // register byte offsets
    localparam logic [7:0] REG_SW_EN = 8'h00;
    localparam logic [7:0] REG_RAIL_STAT = 8'h04;
    localparam logic [7:0] REG_PWR_STATE = 8'h08;
    localparam logic [7:0] REG_VID_STAT = 8'h0C;
    localparam logic [31:0] SW_EN_RESET = 32'h0000_0000;

    // field positions
    localparam int PWR_STATE_LSB = 0;
    localparam int PWR_BUSY_BIT = 8;
    localparam int VID_CMD_CNT_LSB = 8;

    // rail bit positions, low index powers up first and down last
    localparam int RAIL_AON_1V0 = 0;
    localparam int RAIL_AON_1V8 = 1;
    localparam int RAIL_AON_3V3 = 2;
    localparam int RAIL_AON_1V2 = 3;
    localparam int RAIL_INTERNAL_LOGIC = 4;
    localparam int RAIL_USB_PHY = 5;
    localparam int RAIL_MEM_IO = 6;
    localparam int RAIL_MEM_REF0 = 7;
    localparam int RAIL_MEM_REF1 = 8;
    localparam int RAIL_USER_1V8 = 9;
    localparam int RAIL_SYS_USER = 10;
    localparam int RAIL_USER_3V3 = 11;
    localparam int RAIL_GFX_SUPPLY = 12;
    localparam int RAIL_SOC_1V05 = 13;
    localparam int RAIL_SLEEP_1V8 = 14;
    localparam int RAIL_SLEEP_3V3 = 15;
    localparam int RAIL_SLEEP_1V0 = 16;
    localparam int RAIL_PERIPH_2V85 = 17;
    localparam int RAIL_PERIPH_5V = 18;
    localparam int RAIL_MEM_TERM = 19;
    localparam int RAIL_SLEEP_1V2 = 20;
    localparam int RAIL_SD_CARD = 21;
    localparam int RAIL_VIDEO_OUT = 22;
    localparam int RAIL_SYS_SWITCHED = 23;
    localparam int RAIL_SYS_ACTIVE = 24;
    localparam int RAIL_ACTIVE_2V85 = 25;
    localparam int RAIL_USB_HOST_POWER = 26;
    localparam int RAIL_USB_BUS_POWER = 27;
    localparam int RAIL_CORE_SUPPLY = 28;
    localparam int RAIL_ACTIVE_1V2 = 29;
    localparam int RAIL_ACTIVE_1V0 = 30;
    localparam int RAIL_ACTIVE_1V8_SWITCH = 31;

    // rails permitted per power state
    localparam logic [31:0] PERM_MECH = 32'h0000_0000;
    localparam logic [31:0] PERM_HIB = 32'h0000_003F;
    localparam logic [31:0] PERM_SUSP = 32'h0000_0FFF;
    localparam logic [31:0] PERM_IDLE = 32'h0FFF_FFFF;
    localparam logic [31:0] PERM_FULL = 32'hFFFF_FFFF;
    // rails gated by software bits, and rails gated by link commands
    localparam logic [31:0] OD_MASK = 32'h8FE0_0C00;
    localparam logic [31:0] VID_MASK = 32'h1000_1000;

    // link command layout and codes
    localparam int VID_WORD_W = 9;
    localparam int VID_ADDR_W = 4;
    localparam int VID_CODE_W = 5;
    localparam int VID_RESP_W = 5;
    localparam logic [3:0] VID_ADDR_CORE = 4'h0;
    localparam logic [3:0] VID_ADDR_GFX = 4'h1;
    localparam logic [4:0] VID_CMD_ON = 5'h01;
    localparam logic [4:0] VID_CMD_OFF = 5'h02;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEQ_STEP_NS = 2000;
    localparam int SEQ_STEP_CYC = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PS_MECH = 3'b000,
        PS_HIB = 3'b001,
        PS_SUSP = 3'b010,
        PS_IDLE = 3'b011,
        PS_FULL = 3'b100
    } psr_pstate_type;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_CMD = 2'b01,
        LK_RESP = 2'b10
    } psr_lstate_type;

endpackage

// file: hdl/psr_link_if.sv
// signals between the rail controller and its voltage-id link receiver
`timescale 1ns/1ps
interface psr_link_if;
    logic lclk;
    logic ldat;
    logic warm;
    logic cmd_valid;
    logic [3:0] cmd_addr;
    logic [4:0] cmd_code;
    logic [4:0] core_stat;
    logic [4:0] gfx_stat;
    logic dat_o;
    logic dat_oe;

    modport ctl (output lclk, output ldat, output warm, output core_stat, output gfx_stat,
                 input cmd_valid, input cmd_addr, input cmd_code, input dat_o, input dat_oe);
    modport link (input lclk, input ldat, input warm, input core_stat, input gfx_stat,
                  output cmd_valid, output cmd_addr, output cmd_code, output dat_o, output dat_oe);
endinterface

// file: hdl/psr_vid_link.sv
// voltage-id link receiver: framing, address decode and status reply
`timescale 1ns/1ps
module psr_vid_link
    import psr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    psr_link_if.link lnk
);

    typedef struct packed {
        logic lclk_q;
        psr_lstate_type st;
        logic [3:0] bcnt;
        logic [8:0] shreg;
        logic [4:0] resp;
        logic cmd_valid;
        logic dat_o;
        logic dat_oe;
    } psr_link_state_type;

    psr_link_state_type r, n;
    logic rise, fall;
    logic [8:0] word;

    assign rise = lnk.lclk & ~r.lclk_q;
    assign fall = ~lnk.lclk & r.lclk_q;
    assign word = {r.shreg[7:0], lnk.ldat};

    always_comb begin
        n = r;
        n.lclk_q = lnk.lclk;
        n.cmd_valid = 1'b0;
        case (r.st)
            LK_IDLE: begin
                n.dat_oe = 1'b0;
                if (rise && !lnk.ldat) begin
                    n.st = LK_CMD;
                    n.bcnt = 4'h0;
                end
            end
            LK_CMD: begin
                if (rise) begin
                    n.shreg = word;
                    n.bcnt = r.bcnt + 4'h1;
                    if (r.bcnt == 4'(VID_WORD_W - 1)) begin
                        n.bcnt = 4'h0;
                        // unknown address: no reply, no effect
                        if (word[8:5] == VID_ADDR_CORE || word[8:5] == VID_ADDR_GFX) begin
                            n.cmd_valid = 1'b1;
                            n.resp = (word[8:5] == VID_ADDR_CORE) ? lnk.core_stat : lnk.gfx_stat;
                            n.st = LK_RESP;
                        end else begin
                            n.st = LK_IDLE;
                        end
                    end
                end
            end
            LK_RESP: begin
                if (fall) begin
                    // open drain: drive low for a zero bit, release for a one
                    if (r.bcnt == 4'(VID_RESP_W)) begin
                        n.dat_oe = 1'b0;
                        n.st = LK_IDLE;
                    end else begin
                        n.dat_oe = ~r.resp[VID_RESP_W - 1];
                        n.resp = {r.resp[3:0], 1'b1};
                        n.bcnt = r.bcnt + 4'h1;
                    end
                end
            end
            default: n.st = LK_IDLE;
        endcase
        if (lnk.warm) begin
            n.st = LK_IDLE;
            n.dat_oe = 1'b0;
            n.cmd_valid = 1'b0;
            n.bcnt = 4'h0;
        end
        n.dat_o = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign lnk.cmd_valid = r.cmd_valid;
    assign lnk.cmd_addr = r.shreg[8:5];
    assign lnk.cmd_code = r.shreg[4:0];
    assign lnk.dat_o = r.dat_o;
    assign lnk.dat_oe = r.dat_oe;

    AST_WARM_ABORT: assert property (@(posedge clk) disable iff (rst)
        lnk.warm |=> (r.st == LK_IDLE && !r.dat_oe)) else $error("warm reset left link busy");
    AST_ADDR_FILTER: assert property (@(posedge clk) disable iff (rst)
        r.cmd_valid |-> (r.shreg[8:5] == VID_ADDR_CORE || r.shreg[8:5] == VID_ADDR_GFX))
        else $error("command taken for foreign address");

endmodule // psr_vid_link

// file: hdl/psr_rail_ctrl.sv
// power state decode, rail sequencer and register port
// Notes on behaviour
// - core, active 1v2 and active 1v0 rails on only in full-on state.
// - gfx, soc 1v05, sleep 1v8/3v3/1v0 on in full-on and idle standby only.
// - periph 2v85/5v, memory termination, sleep 1v2 on in full-on and idle standby.
// - memory io, memory refs and user 1v8 on down to suspend-to-ram.
// - always-on rails, internal logic and usb phy off only in mechanical off.
// - seven switched rails follow software bits in full-on and idle standby.
// - sys user and user 3v3 follow software bits down to suspend-to-ram.
// - active 1v8 switch follows its software bit in full-on only.
// - software bits take effect only while the power state permits the rail.
// - host sleep pins select the state; the rails follow from them.
// - core and gfx rails are switched by link commands.
// - rails switch one at a time: all downs first, then ups in order.
// - link word is nine bits: four address bits then five command bits.
// - address 0 reaches the core regulator and answers with its status.
// - address 1 reaches the gfx regulator and answers with its status.
// - idle sleep pin alone never changes the core link enable; the core rail still falls in idle standby.
// - warm reset aborts the link transfer, configuration stays.
`timescale 1ns/1ps
module psr_rail_ctrl
    import psr_pkg::*;
#(
    parameter int STEP_CYC = SEQ_STEP_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [DATA_W-1:0] RD_DATA,
    input wire logic IDLE_SLEEP_N,
    input wire logic SUSPEND_SLEEP_N,
    input wire logic HIBERNATE_SLEEP_N,
    input wire logic SUPPLY_AVAIL,
    input wire logic WARM_RST_N,
    input wire logic VID_LINK_CLOCK,
    input wire logic VID_DATA_I,
    output logic VID_DATA_O,
    output logic VID_DATA_OE,
    output logic [RAIL_N-1:0] RAIL_EN
);

    localparam int SYNC_N = 7;
    localparam int SY_IDLE = 0;
    localparam int SY_SUSP = 1;
    localparam int SY_HIB = 2;
    localparam int SY_AVAIL = 3;
    localparam int SY_WARM_N = 4;
    localparam int SY_LCLK = 5;
    localparam int SY_LDAT = 6;

    typedef struct packed {
        logic [SYNC_N-1:0] sync1;
        logic [SYNC_N-1:0] sync2;
        psr_pstate_type pst;
        logic [RAIL_N-1:0] sw_en;
        logic [1:0] vid_en;
        logic [RAIL_N-1:0] rail;
        logic [RAIL_N-1:0] rail_prev;
        logic [7:0] step_cnt;
        logic tick;
        logic [7:0] cmd_cnt;
        logic [DATA_W-1:0] rd_data;
    } psr_ctrl_state_type;

    psr_ctrl_state_type r, n;
    psr_link_if lnk ();

    logic [RAIL_N-1:0] perm_c;
    logic [RAIL_N-1:0] target_c;
    logic [RAIL_N-1:0] off_need_c;
    logic [RAIL_N-1:0] on_need_c;
    logic [RAIL_N-1:0] off_pick_c;
    logic [RAIL_N-1:0] on_pick_c;
    logic [DATA_W-1:0] rd_mux_c;

    function automatic logic [RAIL_N-1:0] perm_of(input psr_pstate_type s);
        case (s)
            PS_FULL: perm_of = PERM_FULL;
            PS_IDLE: perm_of = PERM_IDLE;
            PS_SUSP: perm_of = PERM_SUSP;
            PS_HIB: perm_of = PERM_HIB;
            default: perm_of = PERM_MECH;
        endcase
    endfunction

    // highest set bit as one-hot, so power-down runs in reverse order
    function automatic logic [RAIL_N-1:0] top_bit(input logic [RAIL_N-1:0] v);
        top_bit = '0;
        for (int i = 0; i < RAIL_N; i++) begin
            if (v[i]) begin
                top_bit = '0;
                top_bit[i] = 1'b1;
            end
        end
    endfunction

    psr_vid_link u_link (
        .clk(CLK),
        .rst(RST),
        .lnk(lnk.link)
    );

    assign lnk.lclk = r.sync2[SY_LCLK];
    assign lnk.ldat = r.sync2[SY_LDAT];
    assign lnk.warm = ~r.sync2[SY_WARM_N];
    assign lnk.core_stat = {2'b00, perm_c[RAIL_CORE_SUPPLY], r.rail[RAIL_CORE_SUPPLY], r.vid_en[0]};
    assign lnk.gfx_stat = {2'b00, perm_c[RAIL_GFX_SUPPLY], r.rail[RAIL_GFX_SUPPLY], r.vid_en[1]};

    // rail gating: state permission over fixed, software and link sources
    always_comb begin
        perm_c = perm_of(r.pst);
        target_c = perm_c & ((~OD_MASK & ~VID_MASK) | (r.sw_en & OD_MASK));
        target_c[RAIL_CORE_SUPPLY] = perm_c[RAIL_CORE_SUPPLY] & r.vid_en[0];
        target_c[RAIL_GFX_SUPPLY] = perm_c[RAIL_GFX_SUPPLY] & r.vid_en[1];
        off_need_c = r.rail & ~target_c;
        on_need_c = target_c & ~r.rail;
        off_pick_c = top_bit(off_need_c);
        on_pick_c = on_need_c & (~on_need_c + 32'h0000_0001);
    end

    always_comb begin
        rd_mux_c = '0;
        case (ADDR)
            REG_SW_EN: rd_mux_c = r.sw_en;
            REG_RAIL_STAT: rd_mux_c = r.rail;
            REG_PWR_STATE: begin
                rd_mux_c[PWR_STATE_LSB +: 3] = r.pst;
                rd_mux_c[PWR_BUSY_BIT] = |(off_need_c | on_need_c);
            end
            REG_VID_STAT: begin
                rd_mux_c[1:0] = r.vid_en;
                rd_mux_c[VID_CMD_CNT_LSB +: 8] = r.cmd_cnt;
            end
            default: rd_mux_c = '0;
        endcase
    end

    always_comb begin
        n = r;
        // pins from outside cross on two flops before use
        n.sync1 = {VID_DATA_I, VID_LINK_CLOCK, WARM_RST_N, SUPPLY_AVAIL,
                   HIBERNATE_SLEEP_N, SUSPEND_SLEEP_N, IDLE_SLEEP_N};
        n.sync2 = r.sync1;
        // last cycle's rails, so the checks below see rises without sampled-value calls
        n.rail_prev = r.rail;

        // deepest request wins; a low pin asks for entry
        if (!r.sync2[SY_AVAIL]) begin
            n.pst = PS_MECH;
        end else if (!r.sync2[SY_HIB]) begin
            n.pst = PS_HIB;
        end else if (!r.sync2[SY_SUSP]) begin
            n.pst = PS_SUSP;
        end else if (!r.sync2[SY_IDLE]) begin
            n.pst = PS_IDLE;
        end else begin
            n.pst = PS_FULL;
        end

        // step pacing gives each rail time to settle before the next moves
        n.tick = 1'b0;
        if (r.step_cnt == 8'(STEP_CYC - 1)) begin
            n.step_cnt = 8'h00;
            n.tick = 1'b1;
        end else begin
            n.step_cnt = r.step_cnt + 8'h01;
        end
        if (r.tick) begin
            if (|off_need_c) begin
                n.rail = r.rail & ~off_pick_c;
            end else begin
                n.rail = r.rail | on_pick_c;
            end
        end

        if (lnk.cmd_valid) begin
            n.cmd_cnt = r.cmd_cnt + 8'h01;
            if (lnk.cmd_code == VID_CMD_ON) begin
                n.vid_en[lnk.cmd_addr[0]] = 1'b1;
            end else if (lnk.cmd_code == VID_CMD_OFF) begin
                n.vid_en[lnk.cmd_addr[0]] = 1'b0;
            end
        end

        if (WR_EN && ADDR == REG_SW_EN) begin
            n.sw_en = WR_DATA & OD_MASK;
        end
        n.rd_data = RD_EN ? rd_mux_c : '0;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign RD_DATA = r.rd_data;
    assign RAIL_EN = r.rail;
    assign VID_DATA_O = lnk.dat_o;
    assign VID_DATA_OE = lnk.dat_oe;

    // the link is sampled by CLK, so a faster link clock than a quarter of CLK cannot be followed

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    logic [RAIL_N-1:0] rise_c;
    assign rise_c = r.rail & ~r.rail_prev;

    sequence s_core_cmd_on;
        lnk.cmd_valid && lnk.cmd_addr == VID_ADDR_CORE && lnk.cmd_code == VID_CMD_ON;
    endsequence

    sequence s_core_en_held;
        r.vid_en[0] [*2];
    endsequence

    AST_ONE_RAIL_PER_STEP: assert property ($countones(r.rail ^ $past(r.rail)) <= 1)
        else $error("more than one rail switched at once");
    AST_SWITCH_ON_TICK: assert property ((r.rail != $past(r.rail)) |-> $past(r.tick))
        else $error("rail switched off the step pace");
    AST_DOWN_BEFORE_UP: assert property ((|rise_c) |-> !$past(|off_need_c))
        else $error("rail raised while another still had to fall");
    AST_UP_IN_ORDER: assert property ((|rise_c) |-> ((rise_c - 32'h0000_0001) & $past(on_need_c)) == '0)
        else $error("rail raised out of order");
    AST_NO_UNPERMITTED_RISE: assert property ((rise_c & ~perm_of($past(r.pst))) == '0)
        else $error("rail raised outside its power state");
    AST_FULL_ONLY: assert property ((r.pst != PS_FULL && r.tick && !(|(r.rail & ~target_c)))
        |=> !r.rail[RAIL_ACTIVE_1V0] && !r.rail[RAIL_ACTIVE_1V2] && !r.rail[RAIL_CORE_SUPPLY]
        && !r.rail[RAIL_ACTIVE_1V8_SWITCH]) else $error("full-on rail left on");
    AST_SW_GATED_RISE: assert property ((rise_c & OD_MASK & ~$past(r.sw_en)) == '0)
        else $error("on-demand rail raised without its bit");
    AST_CORE_BY_LINK: assert property (rise_c[RAIL_CORE_SUPPLY] |-> $past(r.vid_en[0]))
        else $error("core rail raised without link command");
    AST_CORE_CMD: assert property (s_core_cmd_on |=> s_core_en_held)
        else $error("core enable command not applied");
    AST_IDLE_NO_CORE_CMD: assert property ($fell(r.sync2[SY_IDLE]) && r.sync2[SY_HIB] && r.sync2[SY_SUSP]
        && r.sync2[SY_AVAIL] && !lnk.cmd_valid |=> $stable(r.vid_en))
        else $error("idle sleep pin changed core enable");
    AST_STATE_PRIORITY: assert property (r.sync2[SY_AVAIL] && !r.sync2[SY_HIB] |=> r.pst == PS_HIB)
        else $error("hibernate request not decoded first");
    AST_SW_RESET: assert property ($past(RST) |-> r.sw_en == SW_EN_RESET)
        else $error("software enables not cleared by reset");
    AST_MECH_PERM: assert property (r.pst == PS_MECH |-> !(|rise_c))
        else $error("rail raised in mechanical off");

endmodule // psr_rail_ctrl

// file: verif/psr_host_model.sv
// host side model: drives the link clock and pulls the open-drain link data line low
`timescale 1ns/1ps
module psr_host_model (
    input wire logic CLK,
    input wire logic WIRE,
    output logic LCLK,
    output logic HOST_LOW
);
    // half link period in controller clocks, 800 ns period at 100 ns
    localparam int HALF = 4;

    initial begin
        LCLK = 1'b0;
        HOST_LOW = 1'b0;
    end

    // new data after the falling edge, wire sampled at the rise
    task automatic lk_bit(input logic pull, output logic s);
        repeat (HALF) @(posedge CLK);
        LCLK <= 1'b0;
        HOST_LOW <= pull;
        repeat (HALF) @(posedge CLK);
        LCLK <= 1'b1;
        s = WIRE;
    endtask

    // start bit, nbits of the word msb first; a whole word is followed by five reply bits
    task automatic frame(input logic [8:0] word, input int nbits, output logic [4:0] reply);
        logic s;
        reply = 5'h1F;
        lk_bit(1'b1, s);
        for (int i = 8; i > 8 - nbits; i--) begin
            lk_bit(~word[i], s);
        end
        if (nbits == 9) begin
            for (int i = 4; i >= 0; i--) begin
                lk_bit(1'b0, s);
                reply[i] = s;
            end
        end
        // clock parks low between frames, so a cut frame leaves the receiver mid-word
        repeat (HALF) @(posedge CLK);
        LCLK <= 1'b0;
        HOST_LOW <= 1'b0;
        repeat (HALF) @(posedge CLK);
    endtask
endmodule // psr_host_model

// file: verif/tb.sv
// self-checking bench of the rail controller with a host model on the link
`timescale 1ns/1ps
module tb;
    import psr_pkg::*;
    typedef struct packed {
        logic [3:0] pins;
        logic [31:0] sw;
        logic [2:0] st;
    } psr_row_type;
    localparam int STEP = 2;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WR_DATA = '0;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic IDLE_SLEEP_N = 1'b1;
    logic SUSPEND_SLEEP_N = 1'b1;
    logic HIBERNATE_SLEEP_N = 1'b1;
    logic SUPPLY_AVAIL = 1'b0;
    logic WARM_RST_N = 1'b1;
    logic VID_LINK_CLOCK;
    logic VID_DATA_I;
    logic host_low;
    logic [DATA_W-1:0] RD_DATA;
    logic VID_DATA_O;
    logic VID_DATA_OE;
    logic [RAIL_N-1:0] RAIL_EN;
    logic [31:0] tgt = '0;
    logic [31:0] prev_rails = '0;
    logic [31:0] diff;
    logic rst_q = 1'b1;
    logic [31:0] sw_now = '0;
    logic [2:0] st_now = PS_MECH;
    logic [1:0] ln_now = 2'b00;
    int n_mismatch = 0;
    int checks = 0;
    psr_row_type rows [10];

    always #50 CLK = ~CLK;

    // open-drain data line with pull-up: low while either side pulls
    assign VID_DATA_I = ~(VID_DATA_OE | host_low);

    psr_rail_ctrl #(.STEP_CYC(STEP)) psr_rail_ctrl_i (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .RD_DATA(RD_DATA), .IDLE_SLEEP_N(IDLE_SLEEP_N), .SUSPEND_SLEEP_N(SUSPEND_SLEEP_N),
        .HIBERNATE_SLEEP_N(HIBERNATE_SLEEP_N), .SUPPLY_AVAIL(SUPPLY_AVAIL), .WARM_RST_N(WARM_RST_N),
        .VID_LINK_CLOCK(VID_LINK_CLOCK), .VID_DATA_I(VID_DATA_I), .VID_DATA_O(VID_DATA_O),
        .VID_DATA_OE(VID_DATA_OE), .RAIL_EN(RAIL_EN)
    );

    psr_host_model psr_host_model_i (.CLK(CLK), .WIRE(VID_DATA_I), .LCLK(VID_LINK_CLOCK), .HOST_LOW(host_low));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] exp_rails(input logic [2:0] st, input logic [31:0] sw, input logic [1:0] ln);
        logic [31:0] perm;
        logic [31:0] lk;
        perm = (st == PS_FULL) ? PERM_FULL : (st == PS_IDLE) ? PERM_IDLE :
               (st == PS_SUSP) ? PERM_SUSP : (st == PS_HIB) ? PERM_HIB : PERM_MECH;
        lk = 32'h0000_0000;
        lk[RAIL_CORE_SUPPLY] = ln[0];
        lk[RAIL_GFX_SUPPLY] = ln[1];
        return perm & ((~OD_MASK & ~VID_MASK) | (sw & OD_MASK) | (lk & VID_MASK));
    endfunction

    // rails move one at a time: pending downs from the top first, then ups from the bottom
    always @(posedge CLK) begin
        rst_q <= RST;
        prev_rails <= RAIL_EN;
        diff = RAIL_EN ^ prev_rails;
        if (!RST && !rst_q && diff != 32'h0000_0000) begin
            check($countones(diff), 1, "one rail per step");
            if ((RAIL_EN & diff) != 32'h0000_0000) begin
                check((RAIL_EN & ~tgt) | (tgt & ~RAIL_EN & (diff - 1)), 0, "up order");
            end else begin
                check(RAIL_EN & ~tgt & ~(diff - 1), 0, "down order");
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WR_DATA <= v;
        WR_EN <= 1'b1;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
        @(negedge CLK);
        d = RD_DATA;
    endtask

    task automatic settle();
        logic [31:0] d;
        repeat (4) @(posedge CLK);
        for (int i = 0; i < 100; i++) begin
            rd(REG_PWR_STATE, d);
            if (d[PWR_BUSY_BIT] === 1'b0) break;
        end
        check(d[PWR_BUSY_BIT], 0, "sequencer busy");
        check(RAIL_EN, tgt, "rail vector");
    endtask

    // software enables first, then the sleep pins, each settled on its own
    task automatic apply(input psr_row_type r);
        logic [31:0] d;
        sw_now = r.sw;
        tgt = exp_rails(st_now, sw_now, ln_now);
        wr(REG_SW_EN, r.sw);
        settle();
        rd(REG_SW_EN, d);
        check(d, r.sw & OD_MASK, "software enables");
        st_now = r.st;
        tgt = exp_rails(st_now, sw_now, ln_now);
        @(posedge CLK);
        {SUPPLY_AVAIL, HIBERNATE_SLEEP_N, SUSPEND_SLEEP_N, IDLE_SLEEP_N} <= r.pins;
        settle();
        rd(REG_PWR_STATE, d);
        check(d[PWR_STATE_LSB +: 3], r.st, "power state");
    endtask

    // bit 1 of the reply is the rail output, which may still be stepping
    task automatic link(input logic [3:0] a, input logic [4:0] c, input int nb, input logic [1:0] ln,
                        input logic [4:0] mask, input logic [4:0] exp);
        logic [4:0] rep;
        ln_now = ln;
        tgt = exp_rails(st_now, sw_now, ln_now);
        psr_host_model_i.frame({a, c}, nb, rep);
        if (nb == 9) begin
            check(rep & mask, exp, "link reply");
            settle();
        end
    endtask

    task automatic reset_regs();
        logic [31:0] d;
        rd(REG_SW_EN, d);
        check(d, SW_EN_RESET, "enables at reset");
        rd(REG_RAIL_STAT, d);
        check(d, 32'h0000_0000, "rails at reset");
        rd(REG_VID_STAT, d);
        check(d, 32'h0000_0000, "link status at reset");
        rd(REG_PWR_STATE, d);
        check(d, 32'h0000_0000, "state at reset");
    endtask

    initial begin
        #1_500_000;
        n_mismatch++;
        final_report();
    end

    initial begin
        logic [31:0] d;
        rows[0] = '{4'hF, 32'hFFFF_FFFF, PS_FULL};
        rows[1] = '{4'hF, 32'h0000_0000, PS_FULL};
        rows[2] = '{4'hF, 32'h8000_0400, PS_FULL};
        rows[3] = '{4'hE, 32'hFFFF_FFFF, PS_IDLE};
        rows[4] = '{4'hD, 32'hFFFF_FFFF, PS_SUSP};
        rows[5] = '{4'hC, 32'hFFFF_FFFF, PS_SUSP};
        rows[6] = '{4'hB, 32'hFFFF_FFFF, PS_HIB};
        rows[7] = '{4'h8, 32'hFFFF_FFFF, PS_HIB};
        rows[8] = '{4'h7, 32'hFFFF_FFFF, PS_MECH};
        rows[9] = '{4'hF, 32'hFFFF_FFFF, PS_FULL};
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        reset_regs();
        @(negedge CLK);
        check(RD_DATA, 32'h0000_0000, "read data after its cycle");
        rd(8'h10, d);
        check(d, 32'h0000_0000, "unmapped read");
        apply(rows[0]);
        // the reply carries the status as it stood before the command took effect
        link(4'h0, VID_CMD_ON, 9, 2'b01, 5'h1D, 5'h04);
        link(4'h1, VID_CMD_ON, 9, 2'b11, 5'h1D, 5'h04);
        link(4'h5, VID_CMD_ON, 9, 2'b11, 5'h1F, 5'h1F);
        rd(REG_VID_STAT, d);
        check({d[VID_CMD_CNT_LSB +: 8], d[1:0]}, 10'h00B, "link enables and count");
        for (int i = 0; i < 10; i++) begin
            apply(rows[i]);
        end
        link(4'h1, 5'h03, 9, 2'b11, 5'h1F, 5'h07);
        // cut a frame after five bits, then warm reset must resynchronise the receiver
        link(4'h0, VID_CMD_OFF, 5, 2'b11, 5'h00, 5'h00);
        @(posedge CLK);
        WARM_RST_N <= 1'b0;
        repeat (4) @(posedge CLK);
        WARM_RST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(REG_VID_STAT, d);
        check(d[1:0], 2'b11, "link enables kept");
        rd(REG_SW_EN, d);
        check(d, OD_MASK, "enables kept over warm reset");
        link(4'h0, VID_CMD_OFF, 9, 2'b10, 5'h1D, 5'h05);
        wr(REG_RAIL_STAT, 32'h0000_0000);
        rd(REG_RAIL_STAT, d);
        check(d, tgt, "read-only rail status");
        check(VID_DATA_O, 1'b0, "open-drain data value");
        @(posedge CLK);
        {SUPPLY_AVAIL, HIBERNATE_SLEEP_N, SUSPEND_SLEEP_N, IDLE_SLEEP_N} <= 4'h7;
        tgt = 32'h0000_0000;
        RST <= 1'b1;
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        reset_regs();
        final_report();
    end
endmodule // tb
